//--- logic/scr_apb_decode.sv
// APB address decoder for the calibration bank
`default_nettype none
module scr_apb_decode (
  input  wire logic [31:0] paddr,
  output logic      [2:0]  sel,
  output logic             hit
);
  // Word index of a byte address
  function automatic logic [15:0] word_of(input logic [31:0] a);
    return a[17:2];
  endfunction : word_of

  // Map address to register number
  always_comb begin
    sel = 3'h0;
    hit = 1'b1;
    if (paddr[1:0] != 2'h0 || paddr[31:18] != 14'h0) begin
      hit = 1'b0;
    end else begin
      case (word_of(paddr))
        scr_pkg::IDX_CHARGE_PUMP: sel = 3'h0;
        scr_pkg::IDX_VCO_CURRENT: sel = 3'h1;
        scr_pkg::IDX_CAP_ARRAY:   sel = 3'h2;
        scr_pkg::IDX_CONTROL:     sel = 3'h3;
        scr_pkg::IDX_VCO_CHOICE:  sel = 3'h4;
        scr_pkg::IDX_STATUS:      sel = 3'h5;
        default:                  hit = 1'b0;
      endcase
    end
  end
endmodule : scr_apb_decode
`default_nettype wire

//--- logic/scr_cal_seq.sv
// Calibration run sequencer: steps through enabled stages
`default_nettype none
module scr_cal_seq #(
  parameter int STAGE_CYCLES = scr_pkg::STAGE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic        cp_en,
  input  wire logic        vco_en,
  output logic             busy,
  output logic             in_cp,
  output logic             in_vco,
  output logic             in_cap,
  output logic             done
);
  typedef enum logic [4:0] {
    SCR_IDLE = 5'h01, SCR_VCO = 5'h02, SCR_CP = 5'h04, SCR_CAP = 5'h08, SCR_END = 5'h10
  } scr_seq_t;
  typedef struct packed {
    scr_seq_t    st;
    logic [15:0] cnt;
  } scr_seq_state_t;

  // Stage length must fit the 16-bit counter
  if (STAGE_CYCLES < 1 || STAGE_CYCLES > 65535) begin : g_bad_stage
    $error("bad stage length");
  end

  scr_seq_state_t s_q, s_d;
  localparam logic [15:0] LAST = 16'(STAGE_CYCLES - 1);

  // Stage stepping; disabled stages are skipped
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      SCR_IDLE: if (start) begin
        s_d.cnt = 16'h0000;
        s_d.st  = vco_en ? SCR_VCO : (cp_en ? SCR_CP : SCR_CAP);
      end
      SCR_VCO: if (s_q.cnt == LAST) begin
        s_d.cnt = 16'h0000;
        s_d.st  = cp_en ? SCR_CP : SCR_CAP;
      end else s_d.cnt = s_q.cnt + 16'h0001;
      SCR_CP: if (s_q.cnt == LAST) begin
        s_d.cnt = 16'h0000;
        s_d.st  = SCR_CAP;
      end else s_d.cnt = s_q.cnt + 16'h0001;
      SCR_CAP: if (s_q.cnt == LAST) begin
        s_d.st = SCR_END;
      end else s_d.cnt = s_q.cnt + 16'h0001;
      SCR_END: s_d.st = SCR_IDLE;
      default: s_d.st = SCR_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{st: SCR_IDLE, cnt: 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy   = s_q.st != SCR_IDLE;
  assign in_vco = s_q.st == SCR_VCO;
  assign in_cp  = s_q.st == SCR_CP;
  assign in_cap = s_q.st == SCR_CAP;
  assign done   = s_q.st == SCR_END;
endmodule : scr_cal_seq
`default_nettype wire

//--- logic/scr_pkg.sv
// Package for the synthesizer calibration register bank
`default_nettype none
package scr_pkg;
  // Register word indices; the byte address is four times the index
  localparam logic [15:0] IDX_CHARGE_PUMP  = 16'hDF1C;
  localparam logic [15:0] IDX_VCO_CURRENT  = 16'hDF1D;
  localparam logic [15:0] IDX_CAP_ARRAY    = 16'hDF1E;
  localparam logic [15:0] IDX_CONTROL      = 16'hDF1F;
  localparam logic [15:0] IDX_VCO_CHOICE   = 16'hDF25;
  localparam logic [15:0] IDX_STATUS       = 16'hDF40;
  // Field positions
  localparam int CP_RESULT_LSB  = 0;
  localparam int CP_RESULT_W    = 4;
  localparam int CP_STAGE_LSB   = 4;
  localparam int CP_CFG_LSB     = 6;
  localparam int VCO_CUR_W      = 5;
  localparam int VCO_HIGH_BIT   = 5;
  localparam int CAP_W          = 6;
  localparam int CTRL_W         = 7;
  localparam int VCO_CHOICE_BIT = 1;
  // Reset values
  localparam logic [1:0] RST_CP_CFG      = 2'h2;
  localparam logic [1:0] RST_CP_STAGE    = 2'h2;
  localparam logic [3:0] RST_CP_RESULT   = 4'h9;
  localparam logic [4:0] RST_VCO_CUR     = 5'h0A;
  localparam logic       RST_VCO_HIGH    = 1'b0;
  localparam logic [5:0] RST_CAP         = 6'h20;
  localparam logic [6:0] RST_CTRL        = 7'h0D;
  localparam logic [7:0] RST_VCO_CHOICE  = 8'h0B;
  // Calibration stage timing
  localparam int STAGE_TIME_NS  = 1000;
  localparam int CLK_PERIOD_NS  = 25;
  localparam int STAGE_CYCLES   = (STAGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : scr_pkg
`default_nettype wire

//--- logic/scr_regs.sv
// Synthesizer calibration register bank with APB slave
`default_nettype none
module scr_regs #(
  parameter int STAGE_CYCLES = scr_pkg::STAGE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cal_start,
  input  wire logic        deep_sleep_wake,
  input  wire logic [3:0]  cp_result_in,
  input  wire logic [4:0]  vco_cur_result_in,
  input  wire logic        vco_core_result_in,
  input  wire logic [5:0]  cap_result_in,
  output logic      [3:0]  cp_current,
  output logic      [4:0]  vco_current,
  output logic             vco_core_high_select,
  output logic      [5:0]  cap_array,
  output logic      [6:0]  cal_control,
  output logic      [1:0]  cal_config,
  output logic             cal_busy,
  output logic             cal_cp_active,
  output logic             cal_vco_active,
  output logic             cal_cap_active
);
  typedef struct packed {
    logic [1:0]  cp_cfg;
    logic [1:0]  cp_stage;
    logic [3:0]  cp_res;
    logic        vco_high;
    logic [4:0]  vco_cur;
    logic [5:0]  cap;
    logic [6:0]  ctrl;
    logic [7:0]  vco_choice;
    logic        cal_done;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        busy;
    logic        in_cp;
    logic        in_vco;
    logic        in_cap;
  } scr_state_t;

  scr_state_t s_q, s_d;
  logic [2:0] sel;
  logic       hit;
  logic       busy, in_cp, in_vco, in_cap, done;

  // Address decode
  scr_apb_decode u_dec (
    .paddr (paddr),
    .sel   (sel),
    .hit   (hit)
  );

  // Calibration stage sequencer
  scr_cal_seq #(.STAGE_CYCLES(STAGE_CYCLES)) u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (cal_start),
    .cp_en   (s_q.cp_stage != 2'h0),
    .vco_en  (s_q.vco_choice[scr_pkg::VCO_CHOICE_BIT]),
    .busy    (busy),
    .in_cp   (in_cp),
    .in_vco  (in_vco),
    .in_cap  (in_cap),
    .done    (done)
  );

  // Byte lane 0 write qualifier
  function automatic logic lane0_wr(input logic [2:0] s, input logic [2:0] want);
    return psel && penable && pwrite && hit && !s_q.busy && pstrb[0] && s == want;
  endfunction : lane0_wr

  // Next state: bus access, calibration updates, wake reload
  always_comb begin
    s_d       = s_q;
    s_d.ready = psel && !penable;
    // Busy as seen in the access cycle, so the error matches the dropped write
    s_d.err   = psel && !penable && (!hit || (pwrite && (busy || sel == 3'h5)));
    s_d.busy   = busy;
    s_d.in_cp  = in_cp;
    s_d.in_vco = in_vco;
    s_d.in_cap = in_cap;
    if (cal_start) s_d.cal_done = 1'b0;
    if (done) s_d.cal_done = 1'b1;
    // Results captured in each stage
    if (in_cp) s_d.cp_res = cp_result_in;
    if (in_vco) s_d.vco_high = vco_core_result_in;
    if (in_cap) begin
      s_d.vco_cur = vco_cur_result_in;
      s_d.cap     = cap_result_in;
    end
    // Software writes, low byte only; upper bits dropped
    if (lane0_wr(sel, 3'h0)) begin
      s_d.cp_cfg   = pwdata[scr_pkg::CP_CFG_LSB +: 2];
      s_d.cp_stage = pwdata[scr_pkg::CP_STAGE_LSB +: 2];
      s_d.cp_res   = pwdata[scr_pkg::CP_RESULT_LSB +: scr_pkg::CP_RESULT_W];
    end
    if (lane0_wr(sel, 3'h1)) begin
      s_d.vco_high = pwdata[scr_pkg::VCO_HIGH_BIT];
      s_d.vco_cur  = pwdata[scr_pkg::VCO_CUR_W-1:0];
    end
    if (lane0_wr(sel, 3'h2)) s_d.cap = pwdata[scr_pkg::CAP_W-1:0];
    if (lane0_wr(sel, 3'h3)) s_d.ctrl = pwdata[scr_pkg::CTRL_W-1:0];
    if (lane0_wr(sel, 3'h4)) s_d.vco_choice = pwdata[7:0];
    // Wake from deep sleep restores capacitor array
    if (deep_sleep_wake) s_d.cap = scr_pkg::RST_CAP;
    // Read data with zero upper bits
    s_d.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite && hit) begin
      case (sel)
        3'h0: s_d.rdata[7:0] = {s_q.cp_cfg, s_q.cp_stage, s_q.cp_res};
        3'h1: s_d.rdata[7:0] = {2'h0, s_q.vco_high, s_q.vco_cur};
        3'h2: s_d.rdata[7:0] = {2'h0, s_q.cap};
        3'h3: s_d.rdata[7:0] = {1'h0, s_q.ctrl};
        3'h4: s_d.rdata[7:0] = s_q.vco_choice;
        3'h5: s_d.rdata[7:0] = {6'h00, s_q.cal_done, s_q.busy};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{cp_cfg: scr_pkg::RST_CP_CFG, cp_stage: scr_pkg::RST_CP_STAGE,
               cp_res: scr_pkg::RST_CP_RESULT, vco_high: scr_pkg::RST_VCO_HIGH,
               vco_cur: scr_pkg::RST_VCO_CUR, cap: scr_pkg::RST_CAP,
               ctrl: scr_pkg::RST_CTRL, vco_choice: scr_pkg::RST_VCO_CHOICE,
               cal_done: 1'b0, rdata: 32'h0000_0000, ready: 1'b0, err: 1'b0,
               busy: 1'b0, in_cp: 1'b0, in_vco: 1'b0, in_cap: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign prdata               = s_q.rdata;
  assign pready               = s_q.ready;
  assign pslverr              = s_q.err;
  assign cp_current           = s_q.cp_res;      // Current = base * 2^(value/4)
  assign vco_current          = s_q.vco_cur;
  assign vco_core_high_select = s_q.vco_high;
  assign cap_array            = s_q.cap;
  assign cal_control          = s_q.ctrl;
  assign cal_config           = s_q.cp_cfg;
  assign cal_busy             = s_q.busy;
  assign cal_cp_active        = s_q.in_cp;
  assign cal_vco_active       = s_q.in_vco;
  assign cal_cap_active       = s_q.in_cap;
endmodule : scr_regs
`default_nettype wire

//--- test/scr_regs_properties.sv
// Port assertions for the calibration register bank
`default_nettype none
module scr_regs_properties #(
  parameter int STAGE_CYCLES = 2
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [31:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cal_start,
  input wire logic        deep_sleep_wake,
  input wire logic [3:0]  cp_current,
  input wire logic [4:0]  vco_current,
  input wire logic        vco_core_high_select,
  input wire logic [5:0]  cap_array,
  input wire logic [6:0]  cal_control,
  input wire logic        cal_busy
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Accepted register write
  logic wr;
  assign wr = psel && penable && pwrite && pready && pstrb[0] && !cal_busy;
  // Run start and its busy response
  sequence s_start;
    cal_start && !cal_busy;
  endsequence
  sequence s_busy;
    ##[1:2] cal_busy;
  endsequence
  property p_wake;
    deep_sleep_wake |=> cap_array == 6'h20;
  endproperty
  property p_cap;
    wr && paddr == 32'h37C78 && !deep_sleep_wake |=> cap_array == $past(pwdata[5:0]);
  endproperty
  property p_vco;
    wr && paddr == 32'h37C74 |=> {vco_core_high_select, vco_current} == $past(pwdata[5:0]);
  endproperty
  property p_cp;
    wr && paddr == 32'h37C70 |=> cp_current == $past(pwdata[3:0]);
  endproperty
  property p_ctrl;
    wr && paddr == 32'h37C7C |=> cal_control == $past(pwdata[6:0]);
  endproperty
  property p_rd;
    pready && !pwrite && (paddr == 32'h37C74 || paddr == 32'h37C78) |-> prdata[31:6] == 26'h0;
  endproperty
  property p_busy_wr;
    psel && penable && pwrite && cal_busy |-> pready && pslverr;
  endproperty
  property p_start;
    s_start |-> s_busy;
  endproperty
  a_wake: assert property (p_wake) else $error("cap array not reloaded on wake");
  a_cap: assert property (p_cap) else $error("cap array write lost");
  a_vco: assert property (p_vco) else $error("vco current write lost");
  a_cp: assert property (p_cp) else $error("charge pump result write lost");
  a_ctrl: assert property (p_ctrl) else $error("control write lost");
  a_rd: assert property (p_rd) else $error("unused bits read nonzero");
  a_busy_wr: assert property (p_busy_wr) else $error("write during run not refused");
  a_start: assert property (p_start) else $error("run did not start");
endmodule : scr_regs_properties
bind scr_regs scr_regs_properties #(.STAGE_CYCLES(STAGE_CYCLES)) u_scr_regs_properties (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cal_start(cal_start), .deep_sleep_wake(deep_sleep_wake),
  .cp_current(cp_current), .vco_current(vco_current), .vco_core_high_select(vco_core_high_select),
  .cap_array(cap_array), .cal_control(cal_control), .cal_busy(cal_busy)
);
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the calibration register bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_CP = 32'h37C70, A_VCO = 32'h37C74, A_CAP = 32'h37C78;
  localparam logic [31:0] A_CTL = 32'h37C7C, A_SEL = 32'h37C94, A_BAD = 32'h37C80;
  localparam logic [31:0] A_STA = 32'h37D00;
  logic        pclk, presetn, psel, penable, pwrite, cal_start, deep_sleep_wake, core_in;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb, cp_in, cp_cur;
  logic [4:0]  cur_in, vco_cur;
  logic [5:0]  cap_in, cap_arr;
  logic [6:0]  ctrl;
  logic [1:0]  cfg;
  logic        pready, pslverr, err, core_hi, busy, act_cp, act_vco, seen_cp, seen_vco;
  logic        act_cap, seen_cap;
  int          err_count, checked, cyc;
  scr_regs #(.STAGE_CYCLES(4)) u_scr_regs (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cal_start(cal_start), .deep_sleep_wake(deep_sleep_wake),
    .cp_result_in(cp_in), .vco_cur_result_in(cur_in), .vco_core_result_in(core_in),
    .cap_result_in(cap_in), .cp_current(cp_cur), .vco_current(vco_cur),
    .vco_core_high_select(core_hi), .cap_array(cap_arr), .cal_control(ctrl),
    .cal_config(cfg), .cal_busy(busy), .cal_cp_active(act_cp),
    .cal_vco_active(act_vco), .cal_cap_active(act_cap)
  );
  // 40 MHz clock
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  // Stage activity record and hang limit
  always @(posedge pclk) begin
    if (act_cp) seen_cp <= 1'h1;
    if (act_vco) seen_vco <= 1'h1;
    if (act_cap) seen_cap <= 1'h1;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'h0, 8'h0);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0);
  endtask : rdchk
  task automatic t_access();
    xfer(A_VCO, 1'h1, 8'hFF);
    rdchk(A_VCO, 32'h3F);
    chk({26'h0, core_hi, vco_cur}, 32'h3F);
    xfer(A_CAP, 1'h1, 8'hC5);
    rdchk(A_CAP, 32'h05);
    xfer(A_CTL, 1'h1, 8'hFF);
    rdchk(A_CTL, 32'h7F);
    xfer(A_CP, 1'h1, 8'h5A);
    @(posedge pclk);
    chk({28'h0, cp_cur}, 32'hA);
    pstrb <= 4'h0;
    xfer(A_CP, 1'h1, 8'h00);
    pstrb <= 4'hF;
    rdchk(A_CP, 32'h5A);
    xfer(A_BAD, 1'h0, 8'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask : t_access
  task automatic t_wake();
    deep_sleep_wake <= 1'h1;
    @(posedge pclk);
    deep_sleep_wake <= 1'h0;
    rdchk(A_CAP, 32'h20);
    rdchk(A_VCO, 32'h3F);
  endtask : t_wake
  // One calibration run with a refused write inside it
  task automatic run(input logic [7:0] cp_w, input logic [1:0] exp);
    xfer(A_CP, 1'h1, cp_w);
    seen_cp <= 1'h0;
    seen_vco <= 1'h0;
    seen_cap <= 1'h0;
    cal_start <= 1'h1;
    @(posedge pclk);
    cal_start <= 1'h0;
    while (busy !== 1'h1)
      @(posedge pclk);
    xfer(A_CAP, 1'h1, 8'h3F);
    chk({31'h0, err}, 32'h1);
    while (busy !== 1'h0)
      @(posedge pclk);
    chk({29'h0, seen_cap, seen_cp, seen_vco}, {29'h0, 1'h1, exp});
  endtask : run
  initial begin
    {presetn, psel, penable, pwrite, cal_start, deep_sleep_wake, seen_cp, seen_vco, seen_cap} = '0;
    {paddr, pwdata, err_count, checked, cyc} = '0;
    {cp_in, cur_in, core_in, cap_in} = {4'h6, 5'h13, 1'h1, 6'h2B};
    pstrb = 4'hF;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    rdchk(A_CP, 32'hA9);
    chk({30'h0, cfg}, 32'h2);
    rdchk(A_VCO, 32'h0A);
    rdchk(A_CAP, 32'h20);
    rdchk(A_CTL, 32'h0D);
    rdchk(A_SEL, 32'h0B);
    t_access();
    t_wake();
    run(8'h80, 2'h1);
    rdchk(A_CP, 32'h80);
    rdchk(A_VCO, 32'h33);
    rdchk(A_CAP, 32'h2B);
    rdchk(A_STA, 32'h2);
    xfer(A_STA, 1'h1, 8'h03);
    chk({31'h0, err}, 32'h1);
    xfer(A_SEL, 1'h1, 8'h09);
    {cp_in, cur_in, core_in, cap_in} <= {4'h6, 5'h07, 1'h0, 6'h11};
    run(8'h90, 2'h2);
    rdchk(A_CP, 32'h96);
    rdchk(A_VCO, 32'h27);
    rdchk(A_CAP, 32'h11);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
